// ### hw/xbdec_cfg.svh
`ifndef XBDEC_CFG_SVH
`define XBDEC_CFG_SVH

// ==========================================================
// Fixed windows, upper address bits [23:8]
`define XBDEC_CAN1_PAGE 16'h00EF
`define XBDEC_CAN2_PAGE 16'h00EE
`define XBDEC_RTC_PAGE 16'h00ED
`define XBDEC_PWM_PAGE 16'h00EC
`define XBDEC_MISC_PAGE 16'h00EB
`define XBDEC_I2C_PAGE 16'h00EA
`define XBDEC_ASC_PAGE 16'h00E9
`define XBDEC_SSC_PAGE 16'h00E8
// First RAM area, address bits [23:11]
`define XBDEC_RAM1_BLK 13'h001C
// Test flash block, bits [23:13]
`define XBDEC_TFLASH_BLK 11'h000
// Boot user flash write base, bits [23:16]
`define XBDEC_BOOT_WR_SEG 8'h01
// ==========================================================
// Peripheral enable bit positions
`define XBDEC_EN_CAN1 0
`define XBDEC_EN_CAN2 1
`define XBDEC_EN_RAM1 2
`define XBDEC_EN_RAM2 3
`define XBDEC_EN_RTC 4
`define XBDEC_EN_PWM 6
`define XBDEC_EN_ASC 7
`define XBDEC_EN_SSC 8
`define XBDEC_EN_I2C 9
`define XBDEC_EN_MISC 10
// ==========================================================
// Reset base of second RAM area, bits [23:14]
`define XBDEC_RAM2_BASE_RST 10'h024
// Timing
`define XBDEC_RAM_WAIT 2'h0
`define XBDEC_PERI_WAIT 2'h2
`define XBDEC_CAN_SEG_LINES 4'h4
`define XBDEC_FULL_SEG_LINES 4'h8

`endif

// ### hw/xbdec_pkg.sv
package xbdec_pkg;
  typedef enum logic [3:0] {
    XBDEC_TGT_EXT = 4'h0,
    XBDEC_TGT_RAM1 = 4'h1,
    XBDEC_TGT_RAM2 = 4'h2,
    XBDEC_TGT_CAN1 = 4'h3,
    XBDEC_TGT_CAN2 = 4'h4,
    XBDEC_TGT_RTC = 4'h5,
    XBDEC_TGT_PWM = 4'h6,
    XBDEC_TGT_ASC = 4'h7,
    XBDEC_TGT_SSC = 4'h8,
    XBDEC_TGT_I2C = 4'h9,
    XBDEC_TGT_MISC = 4'hA,
    XBDEC_TGT_TFLASH = 4'hB,
    XBDEC_TGT_FLASH = 4'hC
  } xbdec_target_t;
  typedef enum logic [1:0] {
    XBDEC_IDLE = 2'h0,
    XBDEC_WAIT = 2'h1,
    XBDEC_DONE = 2'h2
  } xbdec_state_t;
endpackage

// ### hw/xbdec_top.sv
// Contract
// RQ1 - First RAM at E000-E7FF when both enabled
// RQ2 - First RAM disabled: range goes external
// RQ3 - Second RAM at programmed base when enabled
// RQ4 - Second RAM base resets to 09'0000h
// RQ5 - Small variant decodes 8K, mirrored per 16K; code leaves upper 8K of the window external
// RQ6 - Large variant decodes 16K, mirrored per 16K
// RQ7 - RAM: 16-bit, zero waits, byte/word
// RQ8 - RAM not stack, registers or bit-addressable
// RQ9 - First CAN at EF00-EFFF, bit 0
// RQ10 - Second CAN at EE00-EEFF, bit 1
// RQ11 - Clock block at ED00-EDFF, bit 4
// RQ12 - PWM at EC00-ECFF, bit 6, words only
// RQ13 - Second async serial at E900, bit 7
// RQ14 - Second sync serial at E800, bit 8
// RQ15 - I2C at EA00-EAFF, bit 9
// RQ16 - Misc registers at EB00-EBFF, bit 10
// RQ17 - Peripherals: word only, two wait states
// RQ18 - CAN in use limits segment lines four
// RQ19 - Disabled peripheral occupies nothing
// RQ20 - One 16M space, byte and word
// RQ21 - Boot mode maps test flash at zero
// RQ22 - Boot flash writes from segment one
// RQ23 - Enabled on-chip region beats external window
// RQ24 - Enabled selects are mutually exclusive
`include "xbdec_cfg.svh"

module xbdec_top #(
  parameter bit LARGE_RAM2 = 1'b0
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic req,
  input wire logic [23:0] addr,
  input wire logic wr,
  input wire logic byte_acc,
  input wire logic stack_acc,
  input wire logic bit_acc,
  input wire logic global_xbus_enable,
  input wire logic [10:0] peripheral_enable_config,
  input wire logic boot_mode,
  input wire logic segment_remap_bit,
  input wire logic base_wr,
  input wire logic [9:0] base_wdata,
  output xbdec_pkg::xbdec_target_t target,
  output logic sel_valid,
  output logic ext_sel,
  output logic refused,
  output logic [1:0] wait_states,
  output logic bus16,
  output logic demux,
  output logic done,
  output logic [9:0] second_ram_base_select,
  output logic [3:0] seg_lines,
  output logic [23:0] mapped_addr
);
  import xbdec_pkg::*;

  // ==========================================================
  // Decode helpers
  function automatic logic page_hit(input logic [23:0] a, input logic [15:0] pg);
    page_hit = (a[23:8] == pg);
  endfunction

  function automatic logic en_bit(input logic g, input logic [10:0] cfg, input int idx);
    en_bit = g & cfg[idx];
  endfunction

  xbdec_state_t state;
  xbdec_target_t next_target;
  logic next_refused;
  logic ram2_hit;
  logic [23:0] next_mapped;
  logic [1:0] wait_cnt;
  logic take;

  // Done cycle blocks a still-held request from retaking
  assign take = (state == XBDEC_IDLE) && req && !done;

  // ==========================================================
  // Base register for second RAM area
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      second_ram_base_select <= `XBDEC_RAM2_BASE_RST; // see RQ4
    end else if (base_wr) begin
      second_ram_base_select <= base_wdata; // see RQ3
    end
  end

  // Window: one 16K block at the base, no repeats; small variant uses low 8K
  always_comb begin
    ram2_hit = (addr[23:14] == second_ram_base_select); // see RQ5 see RQ6
    if (!LARGE_RAM2) begin
      ram2_hit = ram2_hit & ~addr[13]; // see RQ5
    end
  end

  // ==========================================================
  // Target decode; on-chip first, external last
  always_comb begin
    next_target = XBDEC_TGT_EXT; // see RQ2 see RQ19 see RQ23
    if (page_hit(addr, `XBDEC_CAN1_PAGE) &&
        en_bit(global_xbus_enable, peripheral_enable_config, `XBDEC_EN_CAN1)) begin
      next_target = XBDEC_TGT_CAN1; // see RQ9
    end else if (page_hit(addr, `XBDEC_CAN2_PAGE) &&
        en_bit(global_xbus_enable, peripheral_enable_config, `XBDEC_EN_CAN2)) begin
      next_target = XBDEC_TGT_CAN2; // see RQ10
    end else if (page_hit(addr, `XBDEC_RTC_PAGE) &&
        en_bit(global_xbus_enable, peripheral_enable_config, `XBDEC_EN_RTC)) begin
      next_target = XBDEC_TGT_RTC; // see RQ11
    end else if (page_hit(addr, `XBDEC_PWM_PAGE) &&
        en_bit(global_xbus_enable, peripheral_enable_config, `XBDEC_EN_PWM)) begin
      next_target = XBDEC_TGT_PWM; // see RQ12
    end else if (page_hit(addr, `XBDEC_ASC_PAGE) &&
        en_bit(global_xbus_enable, peripheral_enable_config, `XBDEC_EN_ASC)) begin
      next_target = XBDEC_TGT_ASC; // see RQ13
    end else if (page_hit(addr, `XBDEC_SSC_PAGE) &&
        en_bit(global_xbus_enable, peripheral_enable_config, `XBDEC_EN_SSC)) begin
      next_target = XBDEC_TGT_SSC; // see RQ14
    end else if (page_hit(addr, `XBDEC_I2C_PAGE) &&
        en_bit(global_xbus_enable, peripheral_enable_config, `XBDEC_EN_I2C)) begin
      next_target = XBDEC_TGT_I2C; // see RQ15
    end else if (page_hit(addr, `XBDEC_MISC_PAGE) &&
        en_bit(global_xbus_enable, peripheral_enable_config, `XBDEC_EN_MISC)) begin
      next_target = XBDEC_TGT_MISC; // see RQ16
    end else if ((addr[23:11] == `XBDEC_RAM1_BLK) &&
        en_bit(global_xbus_enable, peripheral_enable_config, `XBDEC_EN_RAM1)) begin
      next_target = XBDEC_TGT_RAM1; // see RQ1
    end else if (ram2_hit &&
        en_bit(global_xbus_enable, peripheral_enable_config, `XBDEC_EN_RAM2)) begin
      next_target = XBDEC_TGT_RAM2; // see RQ3
    end else if (boot_mode && !wr && (addr[23:13] == `XBDEC_TFLASH_BLK)) begin
      next_target = XBDEC_TGT_TFLASH; // see RQ21
    end else if (boot_mode && wr && (addr[23:16] == `XBDEC_BOOT_WR_SEG)) begin
      next_target = XBDEC_TGT_FLASH; // see RQ22
    end
  end

  // Access type checks
  always_comb begin
    next_refused = 1'b0;
    case (next_target)
      XBDEC_TGT_RAM1, XBDEC_TGT_RAM2: next_refused = stack_acc | bit_acc; // see RQ8
      XBDEC_TGT_EXT, XBDEC_TGT_TFLASH, XBDEC_TGT_FLASH: next_refused = 1'b0; // see RQ20
      default: next_refused = byte_acc; // see RQ12 see RQ17
    endcase
  end

  // Flash address: boot writes land in segment one, offset to zero
  always_comb begin
    next_mapped = addr;
    if (next_target == XBDEC_TGT_FLASH) begin
      next_mapped = {8'h00, addr[15:0]}; // see RQ22
    end
  end

  // ==========================================================
  // Access sequencing
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state <= XBDEC_IDLE;
      wait_cnt <= 2'h0;
      target <= XBDEC_TGT_EXT;
      sel_valid <= 1'b0;
      ext_sel <= 1'b0;
      refused <= 1'b0;
      wait_states <= 2'h0;
      bus16 <= 1'b0;
      demux <= 1'b0;
      done <= 1'b0;
      mapped_addr <= 24'h000000;
    end else begin
      done <= 1'b0;
      case (state)
        XBDEC_IDLE: begin
          if (take) begin
            target <= next_target;
            mapped_addr <= next_mapped;
            refused <= next_refused;
            ext_sel <= (next_target == XBDEC_TGT_EXT); // see RQ2
            sel_valid <= (next_target != XBDEC_TGT_EXT) & ~next_refused; // see RQ24
            bus16 <= (next_target != XBDEC_TGT_EXT); // see RQ7 see RQ17
            demux <= (next_target != XBDEC_TGT_EXT); // see RQ7 see RQ17
            if ((next_target == XBDEC_TGT_RAM1) || (next_target == XBDEC_TGT_RAM2) ||
                (next_target == XBDEC_TGT_EXT) || (next_target == XBDEC_TGT_TFLASH) ||
                (next_target == XBDEC_TGT_FLASH) || next_refused) begin
              wait_states <= `XBDEC_RAM_WAIT; // see RQ7
              state <= XBDEC_DONE;
            end else begin
              wait_states <= `XBDEC_PERI_WAIT; // see RQ17
              wait_cnt <= `XBDEC_PERI_WAIT - 2'h1;
              state <= XBDEC_WAIT;
            end
          end
        end
        XBDEC_WAIT: begin
          if (wait_cnt == 2'h0) begin
            state <= XBDEC_DONE;
          end else begin
            wait_cnt <= wait_cnt - 2'h1;
          end
        end
        XBDEC_DONE: begin
          done <= 1'b1;
          sel_valid <= 1'b0;
          ext_sel <= 1'b0;
          state <= XBDEC_IDLE;
        end
        default: state <= XBDEC_IDLE;
      endcase
    end
  end

  // Segment line limit when any CAN is in use
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      seg_lines <= `XBDEC_FULL_SEG_LINES;
    end else if (en_bit(global_xbus_enable, peripheral_enable_config, `XBDEC_EN_CAN1) ||
                 en_bit(global_xbus_enable, peripheral_enable_config, `XBDEC_EN_CAN2)) begin
      seg_lines <= `XBDEC_CAN_SEG_LINES; // see RQ18
    end else begin
      seg_lines <= `XBDEC_FULL_SEG_LINES;
    end
  end

  // ==========================================================
  // Checks
  AST_CAN1_SEL: assert property (@(posedge clock) disable iff (!rst_b) // see RQ9
    (take && addr[23:8] == 16'h00EF && global_xbus_enable &&
     peripheral_enable_config[0]) |=> target == XBDEC_TGT_CAN1)
    else $error("first CAN not selected");
  AST_RAM1_OFF: assert property (@(posedge clock) disable iff (!rst_b) // see RQ2
    (take && addr[23:11] == 13'h001C && !global_xbus_enable)
    |=> target == XBDEC_TGT_EXT)
    else $error("disabled first RAM not external");
  AST_RAM1_ON: assert property (@(posedge clock) disable iff (!rst_b) // see RQ1
    (take && addr[23:11] == 13'h001C && global_xbus_enable &&
     peripheral_enable_config[2]) |=> target == XBDEC_TGT_RAM1)
    else $error("first RAM not selected");
  AST_PERI_WAIT: assert property (@(posedge clock) disable iff (!rst_b) // see RQ17
    (take && next_target == XBDEC_TGT_RTC && !byte_acc)
    |=> !done ##1 !done ##1 !done ##1 done)
    else $error("peripheral wait count wrong");
  AST_RAM_FAST: assert property (@(posedge clock) disable iff (!rst_b) // see RQ7
    (take && next_target == XBDEC_TGT_RAM1 && !stack_acc && !bit_acc)
    |=> wait_states == 2'h0 ##1 done)
    else $error("RAM access not zero wait");
  AST_BYTE_PERI: assert property (@(posedge clock) disable iff (!rst_b) // see RQ12
    (take && next_target == XBDEC_TGT_PWM && byte_acc)
    |=> refused && !sel_valid)
    else $error("byte access to PWM accepted");
  AST_BASE_RST: assert property (@(posedge clock) // see RQ4
    !rst_b |=> second_ram_base_select == 10'h024)
    else $error("second RAM base reset wrong");
  AST_SEG_CAN: assert property (@(posedge clock) disable iff (!rst_b) // see RQ18
    (global_xbus_enable && peripheral_enable_config[1]) |=> seg_lines == 4'h4)
    else $error("segment lines not limited");
  AST_BOOT_TF: assert property (@(posedge clock) disable iff (!rst_b) // see RQ21
    (take && !boot_mode && addr[23:13] == 11'h000)
    |=> target != XBDEC_TGT_TFLASH)
    else $error("test flash visible in user mode");
  AST_DISABLED: assert property (@(posedge clock) disable iff (!rst_b) // see RQ19
    (take && addr[23:8] == 16'h00EA && !peripheral_enable_config[9])
    |=> target == XBDEC_TGT_EXT)
    else $error("disabled I2C occupies space");

  // ==========================================================
  // Further decode and timing checks
  AST_CAN2_SEL: assert property (@(posedge clock) disable iff (!rst_b) // see RQ10
    (take && addr[23:8] == 16'h00EE && global_xbus_enable && peripheral_enable_config[1])
    |=> target == XBDEC_TGT_CAN2)
    else $error("second CAN not selected");
  AST_RTC_SEL: assert property (@(posedge clock) disable iff (!rst_b) // see RQ11
    (take && addr[23:8] == 16'h00ED && global_xbus_enable && peripheral_enable_config[4])
    |=> target == XBDEC_TGT_RTC)
    else $error("clock block not selected");
  AST_PWM_SEL: assert property (@(posedge clock) disable iff (!rst_b) // see RQ12
    (take && addr[23:8] == 16'h00EC && global_xbus_enable && peripheral_enable_config[6])
    |=> target == XBDEC_TGT_PWM)
    else $error("PWM not selected");
  AST_ASC_SEL: assert property (@(posedge clock) disable iff (!rst_b) // see RQ13
    (take && addr[23:8] == 16'h00E9 && global_xbus_enable && peripheral_enable_config[7])
    |=> target == XBDEC_TGT_ASC)
    else $error("second async serial not selected");
  AST_SSC_SEL: assert property (@(posedge clock) disable iff (!rst_b) // see RQ14
    (take && addr[23:8] == 16'h00E8 && global_xbus_enable && peripheral_enable_config[8])
    |=> target == XBDEC_TGT_SSC)
    else $error("second sync serial not selected");
  AST_I2C_SEL: assert property (@(posedge clock) disable iff (!rst_b) // see RQ15
    (take && addr[23:8] == 16'h00EA && global_xbus_enable && peripheral_enable_config[9])
    |=> target == XBDEC_TGT_I2C)
    else $error("I2C not selected");
  AST_MISC_SEL: assert property (@(posedge clock) disable iff (!rst_b) // see RQ16
    (take && addr[23:8] == 16'h00EB && global_xbus_enable && peripheral_enable_config[10])
    |=> target == XBDEC_TGT_MISC)
    else $error("misc registers not selected");
  AST_RAM2_SEL: assert property (@(posedge clock) disable iff (!rst_b) // see RQ3
    (take && addr[23:14] == second_ram_base_select && addr[23:16] != 8'h00 &&
     (LARGE_RAM2 || !addr[13]) && global_xbus_enable && peripheral_enable_config[3])
    |=> target == XBDEC_TGT_RAM2)
    else $error("second RAM not selected");
  AST_RAM2_SMALL: assert property (@(posedge clock) disable iff (!rst_b) // see RQ5
    (take && !LARGE_RAM2 && addr[23:14] == second_ram_base_select && addr[13])
    |=> target != XBDEC_TGT_RAM2)
    else $error("small second RAM decodes upper half");
  AST_RAM2_OFF: assert property (@(posedge clock) disable iff (!rst_b) // see RQ3
    (take && addr[23:14] == second_ram_base_select && addr[23:16] != 8'h00 && !boot_mode &&
     !(global_xbus_enable && peripheral_enable_config[3])) |=> target == XBDEC_TGT_EXT)
    else $error("disabled second RAM not external");
  AST_RAM_REFUSE: assert property (@(posedge clock) disable iff (!rst_b) // see RQ8
    (take && addr[23:11] == 13'h001C && global_xbus_enable && peripheral_enable_config[2] &&
     (stack_acc || bit_acc)) |=> refused && !sel_valid)
    else $error("stack or bit access to RAM accepted");
  AST_RAM1_ACCEPT: assert property (@(posedge clock) disable iff (!rst_b) // see RQ7
    (take && addr[23:11] == 13'h001C && global_xbus_enable && peripheral_enable_config[2] &&
     !stack_acc && !bit_acc) |=> sel_valid && !refused)
    else $error("plain RAM access refused");
  AST_PERI_TIMING: assert property (@(posedge clock) disable iff (!rst_b) // see RQ17
    (sel_valid && !(target inside {XBDEC_TGT_RAM1, XBDEC_TGT_RAM2, XBDEC_TGT_TFLASH,
     XBDEC_TGT_FLASH})) |-> wait_states == 2'h2 && bus16 && demux)
    else $error("peripheral timing wrong");
  AST_RAM_TIMING: assert property (@(posedge clock) disable iff (!rst_b) // see RQ7
    (sel_valid && (target inside {XBDEC_TGT_RAM1, XBDEC_TGT_RAM2}))
    |-> wait_states == 2'h0 && bus16 && demux)
    else $error("RAM timing wrong");
  AST_ONE_SEL: assert property (@(posedge clock) disable iff (!rst_b) // see RQ24
    !(sel_valid && ext_sel))
    else $error("on-chip and external select together");
  AST_EXT_BYTE: assert property (@(posedge clock) disable iff (!rst_b) // see RQ20
    (take && !global_xbus_enable && !boot_mode)
    |=> target == XBDEC_TGT_EXT && ext_sel && !refused)
    else $error("external access not accepted");
  AST_BOOT_WR: assert property (@(posedge clock) disable iff (!rst_b) // see RQ22
    (take && boot_mode && wr && addr[23:16] == 8'h01 && addr[23:14] != second_ram_base_select)
    |=> target == XBDEC_TGT_FLASH && mapped_addr[23:16] == 8'h00)
    else $error("boot flash write not mapped");
  AST_SEG_FULL: assert property (@(posedge clock) disable iff (!rst_b) // see RQ18
    !global_xbus_enable |=> seg_lines == 4'h8)
    else $error("segment lines limited without CAN");
  AST_DONE_PULSE: assert property (@(posedge clock) disable iff (!rst_b) // see RQ7
    done |=> !done)
    else $error("done longer than one cycle");

  COV_PERI: cover property (@(posedge clock) state == XBDEC_WAIT ##2 done);
  COV_RAM2: cover property (@(posedge clock) target == XBDEC_TGT_RAM2 && done);
  COV_EXT: cover property (@(posedge clock) ext_sel);
  COV_BOOT: cover property (@(posedge clock) target == XBDEC_TGT_FLASH);
  COV_REFUSED: cover property (@(posedge clock) refused && done);
endmodule

// ### verification/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import xbdec_pkg::*;
  logic clock, rst_b, global_xbus_enable, boot_mode, segment_remap_bit, base_wr;
  logic [10:0] peripheral_enable_config;
  logic [9:0] base_wdata, second_ram_base_select;
  logic req, wr, byte_acc, stack_acc, bit_acc, sel_valid, ext_sel, refused, bus16, demux, done;
  logic [23:0] addr, mapped_addr;
  logic [1:0] wait_states;
  logic [3:0] seg_lines;
  xbdec_target_t target;
  int fails, comparisons, cycle_count, n_ram;
  xbdec_target_t tg [8] = '{XBDEC_TGT_CAN1, XBDEC_TGT_CAN2, XBDEC_TGT_RTC, XBDEC_TGT_PWM,
    XBDEC_TGT_ASC, XBDEC_TGT_SSC, XBDEC_TGT_I2C, XBDEC_TGT_MISC};
  logic [7:0] pg [8] = '{8'hEF, 8'hEE, 8'hED, 8'hEC, 8'hE9, 8'hE8, 8'hEA, 8'hEB};
  int bt [8] = '{0, 1, 4, 6, 7, 8, 9, 10};

  xbdec_top #(.LARGE_RAM2(1'b0)) uut (.clock, .rst_b, .req, .addr, .wr, .byte_acc, .stack_acc,
    .bit_acc, .global_xbus_enable, .peripheral_enable_config, .boot_mode, .segment_remap_bit,
    .base_wr, .base_wdata, .target, .sel_valid, .ext_sel, .refused, .wait_states, .bus16,
    .demux, .done, .second_ram_base_select, .seg_lines, .mapped_addr);
  xbdec_cpu_model cpu (.clock, .done, .sel_valid, .ext_sel, .req, .addr, .wr, .byte_acc,
    .stack_acc, .bit_acc);

  // ==========================================================
  // Checking helpers
  task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic acc(input logic [23:0] a, input logic [3:0] kind, input xbdec_target_t exp);
    cpu.access(a, kind);
    chk("target", 24'(exp), 24'(target));
  endtask
  task automatic finish_test();
    if (fails == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) begin
    cycle_count++;
    if (cycle_count == 3000) begin
      fails++;
      finish_test();
    end
  end

  // ==========================================================
  // Test sequence
  initial begin
    {rst_b, global_xbus_enable, boot_mode, segment_remap_bit, base_wr} = 5'h00;
    peripheral_enable_config = 11'h000;
    base_wdata = 10'h000;
    repeat (6) @(posedge clock);
    #1;
    rst_b = 1'b1;
    chk("base", 24'(10'h024), 24'(second_ram_base_select));
    chk("seg", 24'h000008, 24'(seg_lines));
    global_xbus_enable = 1'b1;
    peripheral_enable_config = 11'h7DF;
    acc(24'h00E000, 4'h4, XBDEC_TGT_RAM1);
    chk("wait", 24'h000000, 24'(wait_states));
    chk("bus16", 24'h000001, 24'(bus16));
    n_ram = cpu.cycles;
    acc(24'h00E7FE, 4'h8, XBDEC_TGT_RAM1);
    chk("seg", 24'h000004, 24'(seg_lines));
    cpu.access(24'h00E100, 4'h2);
    chk("refused", 24'h000001, 24'(refused));
    cpu.access(24'h00E102, 4'h1);
    chk("refused", 24'h000001, 24'(refused));
    chk("sel", 24'h000000, 24'(cpu.seen_sel));
    acc(24'h090000, 4'h0, XBDEC_TGT_RAM2);
    acc(24'h091FFE, 4'h4, XBDEC_TGT_RAM2);
    acc(24'h092000, 4'h0, XBDEC_TGT_EXT);
    base_wdata = 10'h030;
    base_wr = 1'b1;
    @(posedge clock);
    #1;
    base_wr = 1'b0;
    chk("base", 24'(10'h030), 24'(second_ram_base_select));
    acc(24'h0C0010, 4'h0, XBDEC_TGT_RAM2);
    acc(24'h090000, 4'h0, XBDEC_TGT_EXT);
    peripheral_enable_config[3] = 1'b0;
    acc(24'h0C0010, 4'h0, XBDEC_TGT_EXT);
    peripheral_enable_config[2] = 1'b0;
    acc(24'h00E000, 4'h0, XBDEC_TGT_EXT);
    chk("ext", 24'h000001, 24'(cpu.seen_ext));
    peripheral_enable_config = 11'h7DF;
    for (int i = 0; i < 8; i++) begin
      acc({8'h00, pg[i], 8'hFE}, 4'h0, tg[i]);
      chk("wait", 24'h000002, 24'(wait_states));
      chk("demux", 24'h000001, 24'(demux));
      chk("sel", 24'h000001, 24'(cpu.seen_sel));
      chk("cycles", 24'(n_ram + 2), 24'(cpu.cycles));
      peripheral_enable_config[bt[i]] = 1'b0;
      acc({8'h00, pg[i], 8'h00}, 4'h0, XBDEC_TGT_EXT);
      peripheral_enable_config[bt[i]] = 1'b1;
    end
    cpu.access(24'h00EC10, 4'h4);
    chk("refused", 24'h000001, 24'(refused));
    global_xbus_enable = 1'b0;
    acc(24'h00EF00, 4'h0, XBDEC_TGT_EXT);
    acc(24'h00E000, 4'h0, XBDEC_TGT_EXT);
    global_xbus_enable = 1'b1;
    peripheral_enable_config = 11'h7DC;
    acc(24'hFF0001, 4'h4, XBDEC_TGT_EXT);
    chk("refused", 24'h000000, 24'(refused));
    chk("seg", 24'h000008, 24'(seg_lines));
    boot_mode = 1'b1;
    segment_remap_bit = 1'b1;
    acc(24'h000100, 4'h0, XBDEC_TGT_TFLASH);
    acc(24'h010100, 4'h8, XBDEC_TGT_FLASH);
    chk("mapped", 24'h000100, mapped_addr);
    boot_mode = 1'b0;
    cpu.access(24'h000100, 4'h0);
    chk("tflash", 24'h000000, 24'(target === XBDEC_TGT_TFLASH));
    finish_test();
  end
endmodule

// ### verification/xbdec_cpu_model.sv
// ==========================================================
// Bus master side of the decoder
module xbdec_cpu_model (
  input wire logic clock,
  input wire logic done,
  input wire logic sel_valid,
  input wire logic ext_sel,
  output logic req,
  output logic [23:0] addr,
  output logic wr,
  output logic byte_acc,
  output logic stack_acc,
  output logic bit_acc
);
  timeunit 1ns;
  timeprecision 1ps;
  int cycles;
  logic seen_sel, seen_ext;
  initial begin
    {req, wr, byte_acc, stack_acc, bit_acc, addr} = 29'h0;
  end
  // Request held until done seen at a rising edge
  task automatic access(input logic [23:0] a, input logic [3:0] kind);
    cycles = 0;
    seen_sel = 1'b0;
    seen_ext = 1'b0;
    @(posedge clock);
    #1;
    req = 1'b1;
    addr = a;
    {wr, byte_acc, stack_acc, bit_acc} = kind;
    do begin
      @(posedge clock);
      cycles++;
      if (sel_valid === 1'b1) seen_sel = 1'b1;
      if (ext_sel === 1'b1) seen_ext = 1'b1;
    end while (done !== 1'b1);
    #1;
    req = 1'b0;
    // Released address no longer shows the last value
    addr = ~a;
  endtask
endmodule
